// ==== inc/wwrc_pkg.sv ====
`default_nettype none

package wwrc_pkg;

   // ------------------------------------------------------------
   // Timing base
   // ------------------------------------------------------------
   localparam int CLK_HZ          = 50_000_000;  // Clock rate
   localparam int CLK_NS          = 20;          // Clock period
   // Coefficients of the shared timing base, in base ticks
   localparam int WAKE_PERIOD_CO  = 400_000;     // 4x10^5
   localparam int RST_DELAY_CO    = 50_000;      // 5x10^4
   localparam int RST_TO_WAKE_CO  = 200_000;     // 2x10^5
   // Common divisor giving the 8:1:4 proportion in base units
   localparam int BASE_UNIT_CO    = 50_000;
   localparam int WAKE_UNITS      = WAKE_PERIOD_CO / BASE_UNIT_CO;  // 8
   localparam int RST_UNITS       = RST_DELAY_CO / BASE_UNIT_CO;    // 1
   localparam int R2W_UNITS       = RST_TO_WAKE_CO / BASE_UNIT_CO;  // 4
   localparam int HALF_UNITS      = WAKE_UNITS / 2;                 // 4
   // Base unit time: 40 ms period / 8 = 5 ms
   localparam int UNIT_US         = 5000;
   localparam int UNIT_CYC        = (UNIT_US * 1000) / CLK_NS;      // 250000
   localparam int UNIT_W          = 18;          // Width of unit counter
   localparam int UCNT_W          = 4;           // Width of unit count
   localparam logic [1:0] SYNC_RST = 2'h3;       // Idle-high synchroniser

   // ------------------------------------------------------------
   // Sequencer states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      WWRC_RESET = 2'b00,  // Reset asserted
      WWRC_DELAY = 2'b01,  // Reset released, waiting first wake edge
      WWRC_HIGH  = 2'b10,  // Wake output high half
      WWRC_LOW   = 2'b11   // Wake output low half
   } wwrc_state_t;

endpackage : wwrc_pkg

`default_nettype wire

// ==== rtl/wwrc_tick.sv ====
`timescale 1ns/1ps
`default_nettype none

// Free-running timing base producing one pulse per base unit
module wwrc_tick #(
   parameter int UNIT_CYC = wwrc_pkg::UNIT_CYC,
   parameter int W        = wwrc_pkg::UNIT_W
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic arst_n,
   // Restart and tick
   input  wire logic restart,
   output logic      tick
);

   logic [W-1:0] cnt;       // Cycle count within a unit
   logic [W-1:0] next_cnt;  // Next count
   logic         next_tick; // Next tick

   // ------------------------------------------------------------
   // Next count
   // ------------------------------------------------------------
   always_comb begin
      next_tick = 1'b0;
      if (restart) begin
         next_cnt = '0;                           // Start unit afresh
      end else if (cnt == W'(UNIT_CYC - 1)) begin
         next_cnt  = '0;
         next_tick = 1'b1;
      end else begin
         next_cnt = cnt + 1'b1;
      end
   end

   // Registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt  <= '0;
         tick <= 1'b0;
      end else begin
         cnt  <= next_cnt;
         tick <= next_tick;
      end
   end

endmodule : wwrc_tick

`default_nettype wire

// ==== rtl/wwrc_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none

// Function
// - Wake output high for at most the first half of each period
// - First watchdog fall drives wake low
// - Later watchdog pulses in cycle ignored
// - Reset held until power good at start
// - Reset asserted while power not good
// - Reset held for delay after recovery
// - Missing watchdog edge gives reset pulse
// - Wake output low during any reset
// - Wake cycle restarts after reset delay
// - Period, reset, delay timed 8:1:4
module wwrc_ctrl #(
   parameter int UNIT_CYC = wwrc_pkg::UNIT_CYC  // Cycles per base unit
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic arst_n,
   // Supervisor inputs
   input  wire logic power_good,
   input  wire logic watchdog_pulse_in,
   // Processor outputs
   output logic      wake_up,
   output logic      reset_out_n
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [1:0]                   wd_sync;      // Watchdog synchroniser
   logic                         wd_prev;      // Previous synced level
   logic                         wd_fall;      // Falling edge seen
   logic                         tick;         // Base unit pulse
   logic                         restart;      // Restart timing base
   wwrc_pkg::wwrc_state_t        state;        // Sequencer state
   wwrc_pkg::wwrc_state_t        next_state;   // Next state
   logic [wwrc_pkg::UCNT_W-1:0]  ucnt;         // Units elapsed
   logic [wwrc_pkg::UCNT_W-1:0]  next_ucnt;    // Next units
   logic                         seen;         // Watchdog accepted
   logic                         next_seen;    // Next accepted flag
   logic                         next_wake;    // Next wake output
   logic                         next_rst_n;   // Next reset output
   logic                         rst_ok_now;   // Cycle running, no tick

   // ------------------------------------------------------------
   // Timing base
   // ------------------------------------------------------------
   wwrc_tick #(
      .UNIT_CYC (UNIT_CYC),
      .W        (wwrc_pkg::UNIT_W)
   ) u_tick (
      .clk     (clk),
      .arst_n  (arst_n),
      .restart (restart),
      .tick    (tick)
   );

   // Hold base at zero while supply is low, so the reset delay
   // after recovery always spans one full unit
   assign restart = !power_good;

   // ------------------------------------------------------------
   // Watchdog synchroniser and edge detect
   // ------------------------------------------------------------
   // Only the second stage feeds the edge detector
   assign wd_fall = wd_prev && !wd_sync[1];

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wd_sync <= wwrc_pkg::SYNC_RST;
         wd_prev <= 1'b1;
      end else begin
         wd_sync <= {wd_sync[0], watchdog_pulse_in};
         wd_prev <= wd_sync[1];
      end
   end

   // ------------------------------------------------------------
   // Sequencer next values
   // ------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_ucnt  = ucnt;
      next_seen  = seen;
      next_wake  = 1'b0;
      next_rst_n = 1'b0;
      if (!power_good) begin
         // Supply out of regulation: hold reset
         next_state = wwrc_pkg::WWRC_RESET;
         next_ucnt  = '0;
      end else begin
         case (state)
            wwrc_pkg::WWRC_RESET: begin
               // Reset delay after regulation returns
               if (tick) begin
                  if (ucnt == wwrc_pkg::UCNT_W'(wwrc_pkg::RST_UNITS - 1)) begin
                     next_state = wwrc_pkg::WWRC_DELAY;
                     next_ucnt  = '0;
                     next_rst_n = 1'b1;
                  end else begin
                     next_ucnt = ucnt + 1'b1;
                  end
               end
            end
            wwrc_pkg::WWRC_DELAY: begin
               // Reset high, wake waits for restart delay
               next_rst_n = 1'b1;
               if (tick) begin
                  if (ucnt == wwrc_pkg::UCNT_W'(wwrc_pkg::R2W_UNITS - 1)) begin
                     next_state = wwrc_pkg::WWRC_HIGH;
                     next_ucnt  = '0;
                     next_seen  = 1'b0;
                  end else begin
                     next_ucnt = ucnt + 1'b1;
                  end
               end
               next_wake = (next_state == wwrc_pkg::WWRC_HIGH);
            end
            wwrc_pkg::WWRC_HIGH,
            wwrc_pkg::WWRC_LOW: begin
               next_rst_n = 1'b1;
               if (wd_fall && !seen) begin
                  next_seen = 1'b1;
               end
               if (tick) begin
                  if (ucnt == wwrc_pkg::UCNT_W'(wwrc_pkg::HALF_UNITS - 1)) begin
                     next_state = wwrc_pkg::WWRC_LOW;
                  end
                  if (ucnt == wwrc_pkg::UCNT_W'(wwrc_pkg::WAKE_UNITS - 1)) begin
                     next_ucnt = '0;
                     if (next_seen) begin
                        next_state = wwrc_pkg::WWRC_HIGH;  // New cycle
                        next_seen  = 1'b0;
                     end else begin
                        next_state = wwrc_pkg::WWRC_RESET;
                        next_rst_n = 1'b0;
                     end
                  end else begin
                     next_ucnt = ucnt + 1'b1;
                  end
               end
               // High half until an accepted watchdog fall
               next_wake = (next_state == wwrc_pkg::WWRC_HIGH)
                           && !next_seen;
            end
            default: begin
               next_state = wwrc_pkg::WWRC_RESET;
               next_ucnt  = '0;
            end
         endcase
      end
      if (!next_rst_n) begin
         next_wake = 1'b0;
      end
   end

   // Sequencer registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state       <= wwrc_pkg::WWRC_RESET;
         ucnt        <= '0;
         seen        <= 1'b0;
         wake_up     <= 1'b0;
         reset_out_n <= 1'b0;
      end else begin
         state       <= next_state;
         ucnt        <= next_ucnt;
         seen        <= next_seen;
         wake_up     <= next_wake;
         reset_out_n <= next_rst_n;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   // Helper: cycle running, no unit boundary
   assign rst_ok_now = reset_out_n && power_good && !tick;

   sequence s_fall_in_cycle;
      wd_fall && !seen && rst_ok_now;
   endsequence

   wake_in_reset_a: assert property (
      @(posedge clk) disable iff (!arst_n)
      !reset_out_n |-> !wake_up)
      else $error("wake high while reset low");

   pg_reset_a: assert property (
      @(posedge clk) disable iff (!arst_n)
      !power_good |=> !reset_out_n)
      else $error("reset not asserted on power fail");

   wd_drop_a: assert property (
      @(posedge clk) disable iff (!arst_n)
      s_fall_in_cycle |=> !wake_up)
      else $error("wake not dropped after watchdog fall");

   wd_ignore_a: assert property (
      @(posedge clk) disable iff (!arst_n)
      (seen && reset_out_n && !tick) |=> seen)
      else $error("accepted watchdog flag lost in cycle");

   miss_reset_a: assert property (
      @(posedge clk) disable iff (!arst_n)
      (tick && !seen && !wd_fall && power_good
       && (state == wwrc_pkg::WWRC_LOW)
       && ucnt == wwrc_pkg::UCNT_W'(wwrc_pkg::WAKE_UNITS - 1))
      |=> !reset_out_n)
      else $error("no reset after missing watchdog");

   rel_reset_a: assert property (
      @(posedge clk) disable iff (!arst_n)
      $rose(reset_out_n) |-> $past(state) == wwrc_pkg::WWRC_RESET)
      else $error("reset released outside delay");

   wake_rise_a: assert property (
      @(posedge clk) disable iff (!arst_n)
      $rose(wake_up) |-> state == wwrc_pkg::WWRC_HIGH && ucnt == '0)
      else $error("wake rose away from cycle start");

   half_low_a: assert property (
      @(posedge clk) disable iff (!arst_n)
      (state == wwrc_pkg::WWRC_LOW) |-> !wake_up)
      else $error("wake high in low half");

endmodule : wwrc_ctrl

`default_nettype wire

// ==== testbench/wwrc_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// Processor model: in modes 1 and 2 answers each wake rise with watchdog pulses
module wwrc_cpu_model #(
   parameter int DLY     = 50,   // Wake rise to first pulse
   parameter int LOW_CYC = 250   // Phase length, 5 us at 50 MHz
) (
   // Clock
   input  wire logic       clk,
   // Supervisor side
   input  wire logic       wake_up,
   output logic            watchdog_pulse_in,
   // Behaviour: 0 silent, 1 one pulse, 2 two pulses, 3 loopback
   input  wire logic [1:0] mode
);
   logic wake_q;  // Previous wake level
   int   n;       // Position within the answer
   initial begin
      watchdog_pulse_in = 1'h1;
      wake_q = 1'h0;
      n = 0;
   end
   // Answer pattern, driven on the falling edge
   always @(negedge clk) begin
      wake_q <= wake_up;
      if (mode == 2'h3) begin
         watchdog_pulse_in <= wake_up;
      end else if (mode != 2'h0 && wake_up && !wake_q) begin
         n <= 1;
      end else begin
         // Each phase held LOW_CYC cycles
         n <= (n == 0 || n == DLY + 3 * LOW_CYC) ? 0 : n + 1;
         watchdog_pulse_in <= !((n >= DLY && n < DLY + LOW_CYC) ||
            (mode == 2'h2 && n >= DLY + 2 * LOW_CYC &&
             n < DLY + 3 * LOW_CYC));
      end
   end
endmodule : wwrc_cpu_model

`default_nettype wire

// ==== testbench/wakeup_watchdog_reset_ctrl_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module wakeup_watchdog_reset_ctrl_tb_top;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam int U = 400;           // Cycles per base unit
   logic       clk        = 1'h0;    // 50 MHz clock
   logic       arst_n     = 1'h0;    // Async reset
   logic       power_good = 1'h0;    // Regulation flag
   logic [1:0] mode       = 2'h1;    // Processor behaviour
   logic       watchdog_pulse_in;    // From processor
   logic       wake_up;              // To processor
   logic       reset_out_n;          // To processor
   int         fail_count = 0;       // Mismatches
   int         n_tests    = 0;       // Comparisons
   int         cyc        = 0;       // Cycle count

   // ------------------------------------------------------------
   // Instances
   // ------------------------------------------------------------
   wwrc_ctrl #(.UNIT_CYC(U)) dut (
      .clk(clk), .arst_n(arst_n), .power_good(power_good),
      .watchdog_pulse_in(watchdog_pulse_in), .wake_up(wake_up),
      .reset_out_n(reset_out_n));
   wwrc_cpu_model cpu (
      .clk(clk), .wake_up(wake_up),
      .watchdog_pulse_in(watchdog_pulse_in), .mode(mode));

   // Clock and cycle counter
   initial begin
      forever #10 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic check(input string nm, input logic s, input logic e);
      n_tests++;
      if (s !== e) begin
         fail_count++;
         $display("FAIL %s expected %b seen %b", nm, e, s);
      end
   endtask : check

   // Within two cycles of the expected span
   function automatic logic near(input int d, input int e);
      return (d >= e - 2) && (d <= e + 2);
   endfunction : near

   // Bounded wait for a level on wake, reset or watchdog
   task automatic wait_for(input int w, input logic lvl);
      int k;
      k = 0;
      while ((w == 0 ? wake_up : w == 1 ? reset_out_n :
              watchdog_pulse_in) !== lvl && k < 20 * U) begin
         @(posedge clk);
         #1;
         k++;
      end
      if (k >= 20 * U) check("wait", 1'h0, 1'h1);
   endtask : wait_for

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_powerup();
      int t;
      repeat (3 * U) @(negedge clk);
      check("rst_hold", reset_out_n, 1'h0);
      check("wake_rst", wake_up, 1'h0);
      power_good <= 1'h1;
      t = cyc;
      wait_for(1, 1'h1);
      check("rst_dly", cyc - t >= U && cyc - t <= 2 * U + 2, 1'h1);
      t = cyc;
      wait_for(0, 1'h1);
      check("first_wake", near(cyc - t, 4 * U), 1'h1);
   endtask : t_powerup

   task automatic t_normal();
      int t0;
      int t1;
      t0 = cyc;
      wait_for(2, 1'h0);
      t1 = cyc;
      wait_for(0, 1'h0);
      check("wake_fall", cyc - t1 <= 100, 1'h1);
      wait_for(0, 1'h1);
      check("period", near(cyc - t0, 8 * U), 1'h1);
      check("no_rst", reset_out_n, 1'h1);
   endtask : t_normal

   // Second pulse in one cycle changes nothing
   task automatic t_double();
      int t0;
      mode = 2'h2;
      t0 = cyc;
      wait_for(0, 1'h0);
      wait_for(0, 1'h1);
      check("dbl_per", near(cyc - t0, 8 * U), 1'h1);
      check("dbl_rst", reset_out_n, 1'h1);
   endtask : t_double

   // Loopback: plain square wave, no reset
   task automatic t_feedback();
      int t0;
      mode = 2'h3;
      t0 = cyc;
      wait_for(0, 1'h0);
      check("half", near(cyc - t0, 4 * U), 1'h1);
      wait_for(0, 1'h1);
      check("fb_per", near(cyc - t0, 8 * U), 1'h1);
      check("fb_rst", reset_out_n, 1'h1);
   endtask : t_feedback

   task automatic t_missing();
      int t;
      mode = 2'h0;
      t = cyc;
      wait_for(1, 1'h0);
      check("wd_rst", near(cyc - t, 8 * U), 1'h1);
      check("wd_wake", wake_up, 1'h0);
      mode = 2'h1;
      t = cyc;
      wait_for(1, 1'h1);
      check("wd_len", near(cyc - t, U), 1'h1);
      t = cyc;
      wait_for(0, 1'h1);
      check("wd_restart", near(cyc - t, 4 * U), 1'h1);
   endtask : t_missing

   task automatic t_brownout();
      int t;
      repeat (10) @(negedge clk);
      power_good <= 1'h0;
      t = cyc;
      wait_for(1, 1'h0);
      check("bo_fast", cyc - t <= 3, 1'h1);
      check("bo_wake", wake_up, 1'h0);
      repeat (3 * U) @(negedge clk);
      check("bo_hold", reset_out_n, 1'h0);
      power_good <= 1'h1;
      t = cyc;
      wait_for(1, 1'h1);
      check("bo_dly", cyc - t >= U && cyc - t <= 2 * U + 2, 1'h1);
      t = cyc;
      wait_for(0, 1'h1);
      check("bo_wake2", near(cyc - t, 4 * U), 1'h1);
   endtask : t_brownout

   // Verdict and end of run
   task automatic end_of_test();
      if (fail_count == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test

   // Main sequence
   initial begin
      repeat (5) @(negedge clk);
      arst_n <= 1'h1;
      t_powerup();
      t_normal();
      t_double();
      t_feedback();
      t_missing();
      t_brownout();
      end_of_test();
   end

   // Watchdog against a hang
   initial begin
      repeat (100 * U) @(posedge clk);
      fail_count++;
      end_of_test();
   end
endmodule : wakeup_watchdog_reset_ctrl_tb_top

`default_nettype wire
